/* src/cdio_defines.svh */
`ifndef CDIO_DEFINES_SVH
`define CDIO_DEFINES_SVH
// Register word offsets
`define CDIO_REG_CTRL 4'h0
`define CDIO_REG_DEBOUNCE 4'h1
`define CDIO_REG_TWIDTH 4'h2
`define CDIO_REG_STATUS 4'h3
// Control field positions
`define CDIO_CTRL_SRC_LSB 0
`define CDIO_CTRL_SRC_MSB 2
`define CDIO_CTRL_FLIP 4
`define CDIO_CTRL_SWLVL 5
`define CDIO_CTRL_PINSEL 8
// Control bits that software may set
`define CDIO_CTRL_WMASK 32'h0000_0137
// Status field positions
`define CDIO_STAT_RAW 0
`define CDIO_STAT_FILT 1
`define CDIO_STAT_OUT 2
`define CDIO_STAT_TIMER 3
`define CDIO_STAT_LMODE 4
// Reset values
`define CDIO_CTRL_RST 32'h0000_0000
`define CDIO_DEBOUNCE_RST 32'h0000_0064
`define CDIO_TWIDTH_RST 32'h0000_0001
// Timing: clock and timer width limits
`define CDIO_CLK_MHZ 100
`define CDIO_TWIDTH_MIN_US 1
`define CDIO_TWIDTH_MAX_US 60000000
// Reads to unmapped offsets
`define CDIO_UNMAPPED_RD 32'h0000_0000
`endif

/* src/cdio_pkg.sv */
package cdio_pkg;
  // Output source selection codes
  typedef enum logic [2:0] {
    CDIO_SRC_OFF = 3'h0,
    CDIO_SRC_HIGH = 3'h1,
    CDIO_SRC_FRAME = 3'h2,
    CDIO_SRC_LINE = 3'h3,
    CDIO_SRC_EXPO = 3'h4,
    CDIO_SRC_SW = 3'h5,
    CDIO_SRC_TIMER = 3'h6
  } cdio_src_t;
  // Camera timing signals
  typedef struct packed {
    logic frame_window_pulse;
    logic line_period_pulse;
    logic exposure_window_pulse;
  } cdio_timing_t;
  // Avalon request
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cdio_av_req_t;
endpackage

/* src/cdio_debounce.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cdio_defines.svh"
module cdio_debounce #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Sampled input and setting
  input wire logic level_in,
  input wire logic [CW-1:0] interval_in,
  // Filtered result
  output logic filt_out
);
  logic [CW-1:0] stable_cnt; // Cycles the new level has held
  // Accept a new level only after it held for the interval
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      stable_cnt <= '0;
      filt_out <= 1'b0;
    end else if (ce_in) begin
      if (level_in == filt_out) begin
        stable_cnt <= '0; // Short excursion discarded
      end else if (stable_cnt + 1'b1 >= interval_in) begin
        filt_out <= level_in; // Valid after interval
        stable_cnt <= '0;
      end else begin
        stable_cnt <= stable_cnt + 1'b1;
      end
    end
  end
  // Change only to the level sampled the cycle before
  property p_hold;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && filt_out != $past(filt_out)) |-> $past(level_in) == filt_out;
  endproperty
  a_hold: assert property (p_hold) else $error("filter took unstable level");
endmodule // cdio_debounce
`default_nettype wire

/* src/cdio_top.sv */
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "cdio_defines.svh"
module cdio_top
  import cdio_pkg::*;
#(
  parameter int DBW = 32,
  parameter int TWW = 26,
  parameter int US_CYC = `CDIO_CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Camera timing
  input wire cdio_pkg::cdio_timing_t timing_in,
  input wire logic timer_start_in,
  // Pins
  input wire logic trigger_input_pin_in,
  output logic out_pin_out,
  output logic out_pin_oe_out,
  // Filtered trigger
  output logic trigger_filtered_out
);
  import cdio_pkg::*;

  localparam int WMAX_US = `CDIO_TWIDTH_MAX_US;
  localparam int WMIN_US = `CDIO_TWIDTH_MIN_US;

  logic [31:0] ctrl; // Control register
  logic [DBW-1:0] debounce; // Debounce interval in cycles
  logic [TWW-1:0] timer_pulse_width; // Timer width in us
  logic ack; // Answer phase flag
  logic [1:0] pin_sync; // Input synchroniser
  logic filt; // Debounced input
  logic [6:0] us_cnt; // Microsecond prescaler
  logic [TWW-1:0] tmr_cnt; // Remaining microseconds
  logic timer_pulse_output; // Timer pulse
  logic software_driven_output; // Software level signal
  logic sel_sig; // Selected source
  logic next_pin; // Next pin level
  logic io_pin_select; // Line index selector
  cdio_src_t output_source_select; // Source choice
  logic output_polarity_flip; // Inversion
  logic software_output_level; // Software level
  logic [31:0] status; // Read status word
  logic us_tick; // One microsecond tick
  logic [TWW-1:0] wreq; // Clamped width request
  logic [31:0] wd_clamp; // Width from bus

  // Field decode
  assign output_source_select = cdio_src_t'(ctrl[`CDIO_CTRL_SRC_MSB:`CDIO_CTRL_SRC_LSB]);
  assign output_polarity_flip = ctrl[`CDIO_CTRL_FLIP];
  assign software_output_level = ctrl[`CDIO_CTRL_SWLVL];
  assign io_pin_select = ctrl[`CDIO_CTRL_PINSEL];

  // Bus handshake: one wait cycle then ack
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;

  // Ack flag high for one cycle after the first cycle of each request
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ack <= 1'b0;
    end else if (ce_in) begin
      ack <= (avs_read_in | avs_write_in) & ~ack;
    end
  end

  // Clamp width to allowed range
  always_comb begin
    wd_clamp = avs_writedata_in;
    if (wd_clamp < WMIN_US) begin
      wd_clamp = 32'(WMIN_US);
    end else if (wd_clamp > WMAX_US) begin
      wd_clamp = 32'(WMAX_US);
    end
    wreq = wd_clamp[TWW-1:0];
  end

  // Register writes on acked cycle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl <= `CDIO_CTRL_RST;
      debounce <= DBW'(`CDIO_DEBOUNCE_RST);
      timer_pulse_width <= TWW'(`CDIO_TWIDTH_RST);
    end else if (ce_in && avs_write_in && ack) begin
      case (avs_address_in)
        `CDIO_REG_CTRL: begin
          ctrl <= avs_writedata_in & `CDIO_CTRL_WMASK;
        end
        `CDIO_REG_DEBOUNCE: begin
          debounce <= avs_writedata_in[DBW-1:0];
        end
        `CDIO_REG_TWIDTH: begin
          timer_pulse_width <= wreq;
        end
        default: begin
          ctrl <= ctrl; // Unmapped write ignored
        end
      endcase
    end
  end

  // Status word
  always_comb begin
    status = 32'h0000_0000;
    status[`CDIO_STAT_RAW] = pin_sync[1];
    status[`CDIO_STAT_FILT] = filt;
    status[`CDIO_STAT_OUT] = out_pin_out;
    status[`CDIO_STAT_TIMER] = timer_pulse_output;
    status[`CDIO_STAT_LMODE] = io_pin_select;
  end

  // Read data register
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (ce_in && avs_read_in && !ack) begin
      case (avs_address_in)
        `CDIO_REG_CTRL: avs_readdata_out <= ctrl;
        `CDIO_REG_DEBOUNCE: avs_readdata_out <= 32'(debounce);
        `CDIO_REG_TWIDTH: avs_readdata_out <= 32'(timer_pulse_width);
        `CDIO_REG_STATUS: avs_readdata_out <= status;
        default: avs_readdata_out <= `CDIO_UNMAPPED_RD;
      endcase
    end
  end

  // Pin synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      pin_sync <= 2'b00;
    end else if (ce_in) begin
      pin_sync <= {pin_sync[0], trigger_input_pin_in};
    end
  end

  // Glitch filter
  cdio_debounce #(.CW(DBW)) u_deb (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .level_in(pin_sync[1]),
    .interval_in(debounce),
    .filt_out(filt)
  );

  // Filtered level to trigger logic
  assign trigger_filtered_out = filt;

  // Microsecond prescaler
  assign us_tick = (us_cnt == 7'(US_CYC - 1));
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      us_cnt <= 7'h00;
    end else if (ce_in) begin
      if (timer_start_in && !timer_pulse_output) begin
        us_cnt <= 7'h00; // Restart so the pulse spans whole microseconds
      end else begin
        us_cnt <= us_tick ? 7'h00 : us_cnt + 7'h01;
      end
    end
  end

  // Timer pulse of programmed width, started whenever start is high and no pulse runs
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tmr_cnt <= '0;
      timer_pulse_output <= 1'b0;
    end else if (ce_in) begin
      if (timer_start_in && !timer_pulse_output) begin
        tmr_cnt <= timer_pulse_width;
        timer_pulse_output <= 1'b1;
      end else if (timer_pulse_output && us_tick) begin
        if (tmr_cnt <= TWW'(1)) begin
          timer_pulse_output <= 1'b0;
          tmr_cnt <= '0;
        end else begin
          tmr_cnt <= tmr_cnt - 1'b1;
        end
      end
    end
  end

  // Software level signal
  assign software_driven_output = software_output_level;

  // Source multiplexer
  always_comb begin
    case (output_source_select)
      CDIO_SRC_OFF: sel_sig = 1'b0;
      CDIO_SRC_HIGH: sel_sig = 1'b1;
      CDIO_SRC_FRAME: sel_sig = timing_in.frame_window_pulse;
      CDIO_SRC_LINE: sel_sig = timing_in.line_period_pulse;
      CDIO_SRC_EXPO: sel_sig = timing_in.exposure_window_pulse;
      CDIO_SRC_SW: sel_sig = software_driven_output;
      CDIO_SRC_TIMER: sel_sig = timer_pulse_output;
      default: sel_sig = 1'b0;
    endcase
    next_pin = sel_sig ^ output_polarity_flip;
  end

  // Output line register, line one driven unless the source is off
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      out_pin_out <= 1'b0;
      out_pin_oe_out <= 1'b0;
    end else if (ce_in) begin
      out_pin_out <= (output_source_select == CDIO_SRC_OFF) ? 1'b0 : next_pin;
      out_pin_oe_out <= (output_source_select != CDIO_SRC_OFF);
    end
  end

  // Off means no drive
  property p_off;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_OFF) |=> !out_pin_oe_out && !out_pin_out;
  endproperty
  a_off: assert property (p_off) else $error("off source drove pin");

  // Software level with flip
  property p_sw;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_SW)
        |=> out_pin_out == ($past(software_output_level) ^ $past(output_polarity_flip));
  endproperty
  a_sw: assert property (p_sw) else $error("software level wrong");

  // Exposure follows with flip
  property p_expo;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_EXPO)
        |=> out_pin_out == ($past(timing_in.exposure_window_pulse) ^ $past(output_polarity_flip));
  endproperty
  a_expo: assert property (p_expo) else $error("exposure not on pin");

  // Width stays in range
  property p_width;
    @(posedge sys_clk_in) disable iff (srst_in)
      timer_pulse_width >= TWW'(WMIN_US) && timer_pulse_width <= TWW'(WMAX_US);
  endproperty
  a_width: assert property (p_width) else $error("timer width out of range");

  // Trigger only takes the level the filter accepted
  property p_trig;
    @(posedge sys_clk_in) disable iff (srst_in)
      (trigger_filtered_out != $past(trigger_filtered_out))
        |-> $past(pin_sync[1]) == trigger_filtered_out;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not filtered");

  // Line one drives whenever a source is chosen
  property p_oe;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select != CDIO_SRC_OFF) |=> out_pin_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("output line not driven");

  // High source holds the line, flip applied
  property p_high;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_HIGH)
        |=> out_pin_out == !$past(output_polarity_flip);
  endproperty
  a_high: assert property (p_high) else $error("high source not held");

  // Frame window follows with flip
  property p_frame;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_FRAME)
        |=> out_pin_out == ($past(timing_in.frame_window_pulse) ^ $past(output_polarity_flip));
  endproperty
  a_frame: assert property (p_frame) else $error("frame window not on pin");

  // Line period follows with flip
  property p_line;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_LINE)
        |=> out_pin_out == ($past(timing_in.line_period_pulse) ^ $past(output_polarity_flip));
  endproperty
  a_line: assert property (p_line) else $error("line period not on pin");

  // Software source without flip shows the level
  property p_swsrc;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_SW && !output_polarity_flip)
        |=> out_pin_out == $past(software_output_level);
  endproperty
  a_swsrc: assert property (p_swsrc) else $error("software source not on pin");

  // Timer pulse follows with flip
  property p_tsrc;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select == CDIO_SRC_TIMER)
        |=> out_pin_out == ($past(timer_pulse_output) ^ $past(output_polarity_flip));
  endproperty
  a_tsrc: assert property (p_tsrc) else $error("timer pulse not on pin");

  // Flip inverts any driven source
  property p_flip;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && output_source_select != CDIO_SRC_OFF && output_polarity_flip)
        |=> out_pin_out == !$past(sel_sig);
  endproperty
  a_flip: assert property (p_flip) else $error("flip not applied");

  // Start loads the width and realigns the prescaler
  property p_tstart;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && timer_start_in && !timer_pulse_output)
        |=> timer_pulse_output && tmr_cnt == $past(timer_pulse_width) && us_cnt == 7'h00;
  endproperty
  a_tstart: assert property (p_tstart) else $error("timer start not taken");

  // Pulse never ends between microsecond ticks
  property p_tmr_hold;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && timer_pulse_output && !us_tick) |=> timer_pulse_output;
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer pulse cut short");

  // Pulse ends on the tick of its last microsecond
  property p_tmr_end;
    @(posedge sys_clk_in) disable iff (srst_in)
      (ce_in && timer_pulse_output && us_tick && tmr_cnt <= TWW'(1))
        |=> !timer_pulse_output;
  endproperty
  a_tmr_end: assert property (p_tmr_end) else $error("timer pulse too long");
endmodule // cdio_top
`default_nettype wire

/* sim/cdio_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module cdio_partner (
  // Clock
  input wire logic sys_clk_in,
  // Command from the bench
  input wire logic go_in,
  input wire logic [7:0] len_in,
  // Trigger line toward the camera
  output logic pin_out
);
  logic [7:0] left = 8'h00; // High cycles still to drive

  // Holds the trigger line high for the commanded count
  always_ff @(posedge sys_clk_in) begin
    if (go_in) begin
      left <= len_in;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end

  // Line pulled low between pulses
  assign pin_out = (left != 8'h00);
endmodule // cdio_partner
`default_nettype wire

/* sim/cdio_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cdio_top_bench;
  import cdio_pkg::*;
  logic sys_clk_in = 1'b0; // Bench clock
  logic srst_in = 1'b1; // Reset held at start
  cdio_av_req_t rq = '0; // Bus request
  cdio_timing_t tm = '0; // Camera timing levels
  logic tstart = 1'b0; // Timer start
  logic ce = 1'b1; // Clock enable
  logic go = 1'b0; // Partner pulse command
  logic [7:0] plen = 8'h00; // Partner pulse length
  logic pin, opin, ooe, filt, wreq;
  logic [31:0] rdat, got, rnd = 32'h44;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] expq[$], gotq[$]; // Expected and observed notes

  cdio_top DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce),
    .avs_address_in(rq.address), .avs_read_in(rq.read), .avs_write_in(rq.write),
    .avs_writedata_in(rq.writedata), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .timing_in(tm), .timer_start_in(tstart), .trigger_input_pin_in(pin),
    .out_pin_out(opin), .out_pin_oe_out(ooe), .trigger_filtered_out(filt));
  cdio_partner EQ (.sys_clk_in(sys_clk_in), .go_in(go), .len_in(plen), .pin_out(pin));

  // Free-running clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Pseudo-random step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Queue one expected and one observed value
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    expq.push_back(e);
    gotq.push_back(g);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rq <= '{a, !w, w, d};
    do begin
      @(posedge sys_clk_in);
    end while (wreq !== 1'b0);
    got = rdat;
    rq <= '0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    note(e, got);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Result checker, oldest note first
  initial begin
    forever begin
      wait (gotq.size() > 0);
      cmp_count++;
      if (gotq[0] !== expq[0]) begin
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, gotq[0], expq[0]);
      end
      void'(gotq.pop_front());
      void'(expq.pop_front());
    end
  end

  // Hang guard
  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int d;
    logic [2:0] s;
    logic [6:0] lv;
    logic [31:0] c;
    cyc(10);
    srst_in <= 1'b0;
    cyc(1);
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h64);
    rd(4'h2, 32'h1);
    rd(4'hF, 32'h0);
    bus(1'b1, 4'h2, 32'h0);
    rd(4'h2, 32'h1);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0393_8700);
    bus(1'b1, 4'h1, 32'h8);
    // Every source with both polarities and random levels
    for (d = 0; d < 14; d++) begin
      rnd = xs(rnd);
      s = 3'(d >> 1);
      tm <= rnd[2:0];
      c = {23'h0, rnd[8], 2'h0, rnd[5], d[0], 1'b0, s};
      lv = {1'b0, rnd[5], rnd[0], rnd[1], rnd[2], 2'b10};
      bus(1'b1, 4'h0, c);
      rd(4'h0, c);
      rd(4'h3, {27'h0, rnd[8], 1'b0, lv[s] ^ (d[0] & (s != 3'h0)), 2'b00});
      note({30'h0, s != 3'h0, lv[s] ^ (d[0] & (s != 3'h0))}, {30'h0, ooe, opin});
    end
    // Timer pulse of two microseconds
    bus(1'b1, 4'h2, 32'h2);
    bus(1'b1, 4'h0, 32'h6);
    tstart <= 1'b1;
    cyc(1);
    tstart <= 1'b0;
    cyc(3);
    note(32'h1, {31'h0, opin});
    cyc(198);
    note(32'h1, {31'h0, opin});
    cyc(1);
    note(32'h0, {31'h0, opin});
    // Frozen clock enable ignores a start request
    ce <= 1'b0;
    tstart <= 1'b1;
    cyc(1);
    tstart <= 1'b0;
    cyc(3);
    note(32'h0, {31'h0, opin});
    ce <= 1'b1;
    // Short glitch then a held level
    plen <= 8'h04;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(20);
    note(32'h0, {31'h0, filt});
    plen <= 8'h28;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(5);
    note(32'h0, {31'h0, filt});
    cyc(5);
    note(32'h0, {31'h0, filt});
    cyc(1);
    note(32'h1, {31'h0, filt});
    cyc(39);
    note(32'h1, {31'h0, filt});
    cyc(1);
    note(32'h0, {31'h0, filt});
    cyc(2);
    print_verdict();
  end
endmodule // cdio_top_bench
`default_nettype wire
